// ---- core/tm3_pkg.sv ----
// Constants shared by the timer-3 block: register addresses, field positions,
// reset values and clock-select encodings.
// Assumes an 8-bit special-function-register bus with 8-bit addresses.
package tm3_pkg;

  // Special-function register addresses.
  localparam logic [7:0] ADDR_CTRL   = 8'h91; // timer_control_status
  localparam logic [7:0] ADDR_RLD_LO = 8'h92; // reload_low_byte
  localparam logic [7:0] ADDR_RLD_HI = 8'h93; // reload_high_byte
  localparam logic [7:0] ADDR_CNT_LO = 8'h94; // count_low_byte
  localparam logic [7:0] ADDR_CNT_HI = 8'h95; // count_high_byte

  // Field positions inside timer_control_status.
  localparam int BIT_HI_FLAG = 7;
  localparam int BIT_LO_FLAG = 6;
  localparam int BIT_LO_IEN  = 5;
  localparam int BIT_CAPT_EN = 4;
  localparam int BIT_SPLIT   = 3;
  localparam int BIT_RUN     = 2;
  localparam int BIT_XSEL_HI = 1;
  localparam int BIT_XSEL_LO = 0;

  // Values after reset.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // External clock select encodings.
  localparam logic [1:0] XSEL_DIV12 = 2'h0;
  localparam logic [1:0] XSEL_RTC   = 2'h1;
  localparam logic [1:0] XSEL_RSVD  = 2'h2;
  localparam logic [1:0] XSEL_EXT8  = 2'h3;

  // Dividers for the slow count sources.
  localparam int         SYS_DIV     = 12;
  localparam logic [3:0] SYS_DIV_MAX = 4'hb;
  localparam int         EXT_DIV     = 8;

endpackage : tm3_pkg

// ---- core/tm3_src_sync.sv ----
// Synchroniser and rising-edge divider for one free-running count source.
// Assumes src_i is asynchronous to clk_i and slower than half the clock rate.
`timescale 1ns/100ps
module tm3_src_sync #(
  parameter int DIV = 1
)(
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Source and tick.
  input  wire logic src_i,
  output logic      tick_o
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic          meta_r;
  logic          sync_r;
  logic          prev_r;
  logic [CW-1:0] cnt_r;

  // Two-stage synchroniser; only sync_r is looked at downstream.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= src_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Count rising edges; emit one tick every DIV of them.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      cnt_r <= '0;
    else if (sync_r && !prev_r)
      cnt_r <= (cnt_r == CW'(DIV - 1)) ? '0 : CW'(cnt_r + 1'b1);
  end

  assign tick_o = sync_r && !prev_r && (cnt_r == CW'(DIV - 1));

endmodule : tm3_src_sync

// ---- core/tm3_timer.sv ----
// Timer 3: 16-bit auto-reload, split 8-bit auto-reload and capture modes.
// Assumes a single-cycle SFR bus write strobe and a registered read port.
// Contract
// - Split mode runs two 8-bit auto-reload counters, each with its own reload byte.
// - In split mode run control gates only the high byte; low byte always counts.
// - Fast select picks system clock, else select field: div12, oscillator, ext/8.
// - High flag sets on high byte wrap; low flag on low byte wrap.
// - With timer interrupt enabled, every high overflow requests an interrupt.
// - With low enable also set, either byte's overflow requests an interrupt.
// - Hardware never clears the flags; software clears them by writing.
// - Capture event on oscillator rising edge or every 8 ext cycles, per select bit 1.
// - Capture copies the 16-bit count into reload registers and sets high flag.
// - In 16-bit mode the high flag sets on wrap from ffff to the reload value.
// - Low flag sets on every low byte wrap in both modes.
// - Control register at 91, all zero at reset, fields as laid out.
// - In 16-bit mode a full wrap loads the 16-bit reload value.
// - External and oscillator sources are synchronised before advancing the count.
`timescale 1ns/100ps
module tm3_timer (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // SFR bus.
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_rd_i,
  output logic      [7:0] sfr_rdata_o,
  // Bits held in other registers of the core.
  input  wire logic       high_byte_fast_clock_select_i,
  input  wire logic       low_byte_fast_clock_select_i,
  input  wire logic       timer_irq_enable_i,
  // Oscillator sources.
  input  wire logic       rtc_osc_i,
  input  wire logic       ext_osc_i,
  // Interrupt request.
  output logic            timer_irq_o
);

  logic [7:0] ctrl_r;
  logic [7:0] count_low_byte_r;
  logic [7:0] count_high_byte_r;
  logic [7:0] reload_low_byte_r;
  logic [7:0] reload_high_byte_r;
  logic [3:0] div12_r;
  logic       div12_tick;
  logic       rtc_tick;
  logic       ext8_tick;
  logic       xclk_tick;
  logic       tick_lo;
  logic       tick_hi;
  logic       inc_lo;
  logic       inc_hi;
  logic       wrap_lo;
  logic       wrap_hi;
  logic       capture;
  logic       split_mode_enable;
  logic       run_control;
  logic       capture_mode_enable;
  logic [1:0] external_clock_select;
  logic       wr_ctrl;

  assign split_mode_enable     = ctrl_r[tm3_pkg::BIT_SPLIT];
  assign run_control           = ctrl_r[tm3_pkg::BIT_RUN];
  assign capture_mode_enable   = ctrl_r[tm3_pkg::BIT_CAPT_EN];
  assign external_clock_select = ctrl_r[tm3_pkg::BIT_XSEL_HI:tm3_pkg::BIT_XSEL_LO];
  assign wr_ctrl               = sfr_wr_i && (sfr_addr_i == tm3_pkg::ADDR_CTRL);

  // Write decode shared by every byte register.
  function automatic logic hit(input logic [7:0] addr);
    hit = sfr_wr_i && (sfr_addr_i == addr);
  endfunction : hit

  // Oscillator sources pass a two-flop synchroniser before they count.
  tm3_src_sync #(.DIV(1)) u_rtc_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .src_i   (rtc_osc_i),
    .tick_o  (rtc_tick)
  );

  tm3_src_sync #(.DIV(tm3_pkg::EXT_DIV)) u_ext_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .src_i   (ext_osc_i),
    .tick_o  (ext8_tick)
  );

  // System clock divided by 12, as a one-cycle enable.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      div12_r <= 4'h0;
    else
      div12_r <= (div12_r == tm3_pkg::SYS_DIV_MAX) ? 4'h0 : div12_r + 4'h1;
  end
  assign div12_tick = (div12_r == tm3_pkg::SYS_DIV_MAX);

  // Clock source per byte; the reserved select yields no ticks.
  always_comb
  begin
    case (external_clock_select)
      tm3_pkg::XSEL_DIV12: xclk_tick = div12_tick;
      tm3_pkg::XSEL_RTC:   xclk_tick = rtc_tick;
      tm3_pkg::XSEL_EXT8:  xclk_tick = ext8_tick;
      default:             xclk_tick = 1'b0;
    endcase
  end
  assign tick_lo = low_byte_fast_clock_select_i ? 1'b1 : xclk_tick;
  assign tick_hi = high_byte_fast_clock_select_i ? 1'b1 : xclk_tick;

  // Split mode: low byte free-runs, high byte is gated by run. 16-bit mode is
  // clocked by the low byte's source and gated by run.
  assign inc_lo  = split_mode_enable ? tick_lo : (run_control && tick_lo);
  assign wrap_lo = inc_lo && (count_low_byte_r == 8'hff);
  assign inc_hi  = split_mode_enable ? (run_control && tick_hi) : wrap_lo;
  assign wrap_hi = inc_hi && (count_high_byte_r == 8'hff);

  // Capture trigger chosen by select bit 1.
  assign capture = capture_mode_enable &&
                   (external_clock_select[1] ? ext8_tick : rtc_tick);

  // Low counter byte; a software write takes priority over counting.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      count_low_byte_r <= tm3_pkg::BYTE_RESET;
    else if (hit(tm3_pkg::ADDR_CNT_LO))
      count_low_byte_r <= sfr_wdata_i;
    else if (wrap_lo && split_mode_enable)
      count_low_byte_r <= reload_low_byte_r;
    else if (wrap_lo && wrap_hi)
      count_low_byte_r <= reload_low_byte_r;
    else if (inc_lo)
      count_low_byte_r <= count_low_byte_r + 8'h01;
  end

  // High counter byte.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      count_high_byte_r <= tm3_pkg::BYTE_RESET;
    else if (hit(tm3_pkg::ADDR_CNT_HI))
      count_high_byte_r <= sfr_wdata_i;
    else if (wrap_hi)
      count_high_byte_r <= reload_high_byte_r;
    else if (inc_hi)
      count_high_byte_r <= count_high_byte_r + 8'h01;
  end

  // Reload registers; a capture wins over a software write so no timestamp is
  // lost in a collision.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      reload_low_byte_r  <= tm3_pkg::BYTE_RESET;
      reload_high_byte_r <= tm3_pkg::BYTE_RESET;
    end
    else if (capture)
    begin
      reload_low_byte_r  <= count_low_byte_r;
      reload_high_byte_r <= count_high_byte_r;
    end
    else
    begin
      if (hit(tm3_pkg::ADDR_RLD_LO))
        reload_low_byte_r <= sfr_wdata_i;
      if (hit(tm3_pkg::ADDR_RLD_HI))
        reload_high_byte_r <= sfr_wdata_i;
    end
  end

  // Control fields are plain read/write, all zero after reset. The
  // overflow flags share this process so the register has a single driver;
  // hardware only sets them, software writes them, and a set in the cycle of a
  // clearing write wins so no overflow is lost.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      ctrl_r <= tm3_pkg::CTRL_RESET;
    else
    begin
      if (wr_ctrl)
        ctrl_r[5:0] <= sfr_wdata_i[5:0];
      if (wrap_hi || capture)
        ctrl_r[tm3_pkg::BIT_HI_FLAG] <= 1'b1;
      else if (wr_ctrl)
        ctrl_r[tm3_pkg::BIT_HI_FLAG] <= sfr_wdata_i[tm3_pkg::BIT_HI_FLAG];
      if (wrap_lo)
        ctrl_r[tm3_pkg::BIT_LO_FLAG] <= 1'b1;
      else if (wr_ctrl)
        ctrl_r[tm3_pkg::BIT_LO_FLAG] <= sfr_wdata_i[tm3_pkg::BIT_LO_FLAG];
    end
  end

  // Registered read port; unmapped addresses read zero.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      sfr_rdata_o <= 8'h00;
    else if (sfr_rd_i)
    begin
      case (sfr_addr_i)
        tm3_pkg::ADDR_CTRL:   sfr_rdata_o <= ctrl_r;
        tm3_pkg::ADDR_RLD_LO: sfr_rdata_o <= reload_low_byte_r;
        tm3_pkg::ADDR_RLD_HI: sfr_rdata_o <= reload_high_byte_r;
        tm3_pkg::ADDR_CNT_LO: sfr_rdata_o <= count_low_byte_r;
        tm3_pkg::ADDR_CNT_HI: sfr_rdata_o <= count_high_byte_r;
        default:              sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  // Both flags are level sources; software must read both to tell them apart.
  assign timer_irq_o = timer_irq_enable_i &&
                       (ctrl_r[tm3_pkg::BIT_HI_FLAG] ||
                        (ctrl_r[tm3_pkg::BIT_LO_IEN] && ctrl_r[tm3_pkg::BIT_LO_FLAG]));

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_split_low_free: assert property (
    split_mode_enable && !run_control && tick_lo && !hit(tm3_pkg::ADDR_CNT_LO)
    && count_low_byte_r != 8'hff |=> count_low_byte_r == $past(count_low_byte_r) + 8'h01)
    else $error("Low byte did not count in split mode.");
  a_split_high_held: assert property (
    split_mode_enable && !run_control && !hit(tm3_pkg::ADDR_CNT_HI) |=> $stable(count_high_byte_r))
    else $error("High byte moved while stopped.");
  a_low_reload: assert property (
    split_mode_enable && wrap_lo && !hit(tm3_pkg::ADDR_CNT_LO)
    |=> count_low_byte_r == $past(reload_low_byte_r))
    else $error("Low byte missed its reload.");
  a_wide_reload: assert property (
    !split_mode_enable && wrap_hi && !hit(tm3_pkg::ADDR_CNT_HI) && !hit(tm3_pkg::ADDR_CNT_LO)
    |=> {count_high_byte_r, count_low_byte_r} == $past({reload_high_byte_r, reload_low_byte_r}))
    else $error("16-bit reload failed.");
  a_flag_sets: assert property (
    wrap_hi |=> ctrl_r[tm3_pkg::BIT_HI_FLAG] ##0 timer_irq_o == timer_irq_enable_i)
    else $error("High flag or request missing after wrap.");
  a_low_flag: assert property (
    wrap_lo |=> ctrl_r[tm3_pkg::BIT_LO_FLAG])
    else $error("Low flag missing after wrap.");
  a_flag_sticky: assert property (
    ctrl_r[tm3_pkg::BIT_HI_FLAG] && !wr_ctrl |=> ctrl_r[tm3_pkg::BIT_HI_FLAG])
    else $error("High flag cleared without a write.");
  a_capture_copy: assert property (
    capture |=> reload_low_byte_r == $past(count_low_byte_r)
      && reload_high_byte_r == $past(count_high_byte_r) && ctrl_r[tm3_pkg::BIT_HI_FLAG])
    else $error("Capture did not copy the count.");
  a_reserved_idle: assert property (
    external_clock_select == tm3_pkg::XSEL_RSVD && !low_byte_fast_clock_select_i |-> !tick_lo)
    else $error("Reserved select produced ticks.");
  a_irq_low: assert property (
    timer_irq_enable_i && ctrl_r[tm3_pkg::BIT_LO_IEN] && ctrl_r[tm3_pkg::BIT_LO_FLAG] |-> timer_irq_o)
    else $error("Low overflow request missing.");

  c_split_wrap: cover property (split_mode_enable && wrap_lo);
  c_wide_wrap: cover property (!split_mode_enable && wrap_hi);
  c_capture: cover property (capture ##[1:50] capture);
  c_set_clear: cover property (wrap_hi && wr_ctrl);

endmodule : tm3_timer

// ---- sim/tm3_core_model.sv ----
// Processor core model: the party that reads and writes the timer's SFRs.
// Assumes bus signals change at the falling edge and read data lands one cycle later.
`timescale 1ns/100ps
module tm3_core_model (
  // Clock.
  input  wire logic       clk_i,
  // SFR bus.
  output logic      [7:0] sfr_addr_o,
  output logic            sfr_wr_o,
  output logic      [7:0] sfr_wdata_o,
  output logic            sfr_rd_o,
  input  wire logic [7:0] sfr_rdata_i
);
  // Idle bus: strobes low, address parked on an unmapped spot.
  initial
  begin
    sfr_addr_o  = 8'h00;
    sfr_wr_o    = 1'b0;
    sfr_wdata_o = 8'h00;
    sfr_rd_o    = 1'b0;
  end

  // One write; software never picks the reserved source and drops split before capture.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == tm3_pkg::ADDR_CTRL && v[1:0] == tm3_pkg::XSEL_RSVD) v[1:0] = 2'h0;
    if (a == tm3_pkg::ADDR_CTRL && v[4]) v[3] = 1'b0;
    @(negedge clk_i);
    sfr_addr_o  = a;
    sfr_wdata_o = v;
    sfr_wr_o    = 1'b1;
    @(negedge clk_i);
    sfr_wr_o    = 1'b0;
    sfr_wdata_o = ~v;
  endtask : wr

  // One read; both flags come back together and are cleared only by writes.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_o = a;
    sfr_rd_o   = 1'b1;
    @(negedge clk_i);
    sfr_rd_o   = 1'b0;
    d          = sfr_rdata_i;
  endtask : rd
endmodule : tm3_core_model

// ---- sim/tm3_timer_tb.sv ----
// Testbench for the timer: SFR traffic through the core model, slow sources by hand.
// Assumes a 10 MHz clock and a read port that answers one cycle after the strobe.
`timescale 1ns/100ps
module tm3_timer_tb;
  // Clock, reset, side inputs and bus wires.
  logic       clk_i    = 1'b0;
  logic       reset_i  = 1'b1;
  logic       hi_fast  = 1'b0;
  logic       lo_fast  = 1'b0;
  logic       irq_en   = 1'b0;
  logic       rtc      = 1'b0;
  logic       ext      = 1'b0;
  logic       irq;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] d;
  logic       wr;
  logic       rd;
  int         n_errors = 0;
  int         compares = 0;

  // Free-running 100 ns clock.
  always #50 clk_i = ~clk_i;

  tm3_timer u_tm3_timer (
    .clk_i(clk_i), .reset_i(reset_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_wdata_i(wdata), .sfr_rd_i(rd), .sfr_rdata_o(rdata),
    .high_byte_fast_clock_select_i(hi_fast), .low_byte_fast_clock_select_i(lo_fast),
    .timer_irq_enable_i(irq_en), .rtc_osc_i(rtc), .ext_osc_i(ext), .timer_irq_o(irq)
  );

  tm3_core_model u_tm3_core_model (
    .clk_i(clk_i), .sfr_addr_o(addr), .sfr_wr_o(wr), .sfr_wdata_o(wdata),
    .sfr_rd_o(rd), .sfr_rdata_i(rdata)
  );

  // Short names for the core model's bus cycles.
  task automatic w(input logic [7:0] a, input logic [7:0] v);
    u_tm3_core_model.wr(a, v);
  endtask : w

  task automatic r(input logic [7:0] a);
    u_tm3_core_model.rd(a, d);
  endtask : r

  // Exact compare; an unknown never matches.
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Window compare, for counts whose divider phase is not known.
  task automatic chk_in(input string nm, input logic [7:0] lo, input logic [7:0] hi,
                        input logic [7:0] got);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      n_errors++;
      $display("FAIL %s expected %h to %h seen %h", nm, lo, hi, got);
    end
  endtask : chk_in

  // Slow source pulses, three clocks high and three low, so each edge survives sync.
  task automatic pulse(input logic use_ext, input int n);
    repeat (n)
    begin
      ext = use_ext;
      rtc = !use_ext;
      repeat (3) @(negedge clk_i);
      ext = 1'b0;
      rtc = 1'b0;
      repeat (3) @(negedge clk_i);
    end
  endtask : pulse

  // Reset value, a read-back and an unmapped read.
  task automatic t_reset;
    r(8'h91);
    chk("ctrl reset", 8'h00, d);
    r(8'h80);
    chk("unmapped", 8'h00, d);
    w(8'h91, 8'h2f);
    r(8'h91);
    chk("ctrl rw", 8'h2f, d);
    w(8'h91, 8'h00);
  endtask : t_reset

  // Split mode: low byte runs with run off, high byte only with run on.
  task automatic t_split;
    hi_fast = 1'b1;
    lo_fast = 1'b1;
    w(8'h92, 8'hfa);
    w(8'h94, 8'hfc);
    w(8'h95, 8'h40);
    w(8'h91, 8'h08);
    r(8'h95);
    chk("high held", 8'h40, d);
    repeat (8) @(negedge clk_i);
    r(8'h91);
    chk("low flag", 8'h48, d);
    r(8'h94);
    chk_in("low reload", 8'hfa, 8'hff, d);
    w(8'h95, 8'hfe);
    w(8'h91, 8'h0c);
    repeat (8) @(negedge clk_i);
    r(8'h91);
    chk("both flags", 8'hcc, d);
    repeat (20) @(negedge clk_i);
    r(8'h91);
    chk("flags kept", 8'hcc, d);
  endtask : t_split

  // Interrupt request against the flags and both enables, then a clear that
  // meets a low-byte wrap in the same cycle.
  task automatic t_irq;
    irq_en = 1'b1;
    @(negedge clk_i);
    chk("irq high", 8'h01, {7'h00, irq});
    w(8'h91, 8'h48);
    chk("irq low only", 8'h00, {7'h00, irq});
    w(8'h91, 8'h68);
    chk("irq low en", 8'h01, {7'h00, irq});
    irq_en = 1'b0;
    @(negedge clk_i);
    chk("irq gated", 8'h00, {7'h00, irq});
    // The low byte has wrapped every six clocks since split mode began, so this
    // clear lands on a wrap and the set must win; a second clear, once the
    // byte has stopped, empties both flags.
    w(8'h91, 8'h00);
    r(8'h91);
    chk("set beats clear", 8'h40, d);
    w(8'h91, 8'h00);
    repeat (4) @(negedge clk_i);
    r(8'h91);
    chk("flags cleared", 8'h00, d);
  endtask : t_irq

  // Full 16-bit wrap reloads both bytes and sets both flags.
  task automatic t_count16;
    hi_fast = 1'b0;
    w(8'h92, 8'h34);
    w(8'h93, 8'h12);
    w(8'h94, 8'hf0);
    w(8'h95, 8'hff);
    w(8'h91, 8'h04);
    repeat (20) @(negedge clk_i);
    r(8'h91);
    chk("wrap flags", 8'hc4, d);
    r(8'h95);
    chk("reload high", 8'h12, d);
    w(8'h91, 8'h00);
  endtask : t_count16

  // Slow clock choices: system/12, oscillator edges, external/8.
  task automatic t_sources;
    lo_fast = 1'b0;
    w(8'h94, 8'h00);
    w(8'h95, 8'h00);
    w(8'h91, 8'h04);
    repeat (119) @(negedge clk_i);
    w(8'h91, 8'h00);
    r(8'h94);
    chk_in("div12", 8'h09, 8'h0b, d);
    w(8'h94, 8'h00);
    w(8'h91, 8'h05);
    pulse(1'b0, 5);
    repeat (6) @(negedge clk_i);
    w(8'h91, 8'h01);
    r(8'h94);
    chk("rtc ticks", 8'h05, d);
    w(8'h94, 8'h00);
    w(8'h91, 8'h07);
    pulse(1'b1, 16);
    repeat (6) @(negedge clk_i);
    w(8'h91, 8'h03);
    r(8'h94);
    chk("ext ticks", 8'h02, d);
  endtask : t_sources

  // Capture on an oscillator edge, then on eight external cycles.
  task automatic t_capture;
    lo_fast = 1'b1;
    w(8'h92, 8'h00);
    w(8'h93, 8'h00);
    w(8'h94, 8'h00);
    w(8'h95, 8'h00);
    w(8'h91, 8'h14);
    repeat (40) @(negedge clk_i);
    pulse(1'b0, 1);
    repeat (6) @(negedge clk_i);
    r(8'h91);
    chk("capture flag", 8'h94, d);
    r(8'h93);
    chk("capture high", 8'h00, d);
    r(8'h92);
    chk_in("capture low", 8'h20, 8'h60, d);
    w(8'h91, 8'h17);
    pulse(1'b1, 8);
    repeat (6) @(negedge clk_i);
    r(8'h91);
    chk("ext capture", 8'h97, d);
    w(8'h91, 8'h00);
  endtask : t_capture

  // Counts, verdict and end of run.
  task automatic tally_and_finish;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // Main sequence after eight cycles of reset.
  initial
  begin
    repeat (8) @(negedge clk_i);
    reset_i = 1'b0;
    t_reset;
    t_split;
    t_irq;
    t_count16;
    t_sources;
    t_capture;
    tally_and_finish;
  end

  // Watchdog: the tests need well under 1500 cycles.
  initial
  begin
    #(4000 * 100);
    n_errors++;
    tally_and_finish;
  end
endmodule : tm3_timer_tb
